//--- synth_regs.vh
`ifndef SYNTH_REGS_VH
`define SYNTH_REGS_VH
`define ADDR_CHANNEL_DATA    8'hB2
`define ADDR_CHANNEL_CONTROL 8'hB3
`define ADDR_CHANNEL_STATUS  8'hB4
`define FB_WIDTH             20
`define REF_WIDTH            13
`define CTRL_ENABLE_0        0
`define CTRL_SET_SEL_0       1
`define CTRL_TOL4_0          2
`define CTRL_GAIN_0          3
`define CTRL_SWAP_0          4
`define CTRL_ENABLE_1        8
`define CTRL_SET_SEL_1       9
`define CTRL_TOL4_1          10
`define CTRL_GAIN_1          11
`define CTRL_SWAP_1          12
`define CTRL_REF_SRC         15
`define STAT_LOCK_0          0
`define STAT_LOCK_1          1
`define STAT_UNLOCK_EV_0     2
`define STAT_UNLOCK_EV_1     3
`define CTRL_RESET           16'h0000
`define DATA_SEL_FB_LO       2'h0
`define DATA_SEL_FB_HI       2'h1
`define DATA_SEL_REF         2'h2
`define DATA_SEL_COMMIT      2'h3
`endif

//--- synth_channel.v
`timescale 1ns/100ps
`include "synth_regs.vh"
module synth_channel
(
	input  wire                   sys_clk,
	input  wire                   arst_n,
	input  wire                   enable,
	input  wire                   ref_tick,
	input  wire                   vco_tick,
	input  wire                   tol4,
	input  wire                   gain_high,
	input  wire [`FB_WIDTH-1:0]   fb_value,
	input  wire [`REF_WIDTH-1:0]  ref_value,
	output reg                    pump_up,
	output reg                    pump_dn,
	output reg                    pump_oe_n,
	output reg                    pump_gain,
	output reg                    locked
);
	reg [`FB_WIDTH-1:0]  fb_cnt;
	reg [`REF_WIDTH-1:0] ref_cnt;
	reg                  fb_pulse;
	reg                  ref_pulse;
	reg [2:0]            lock_hist;
	reg [2:0]            err_cnt;
	wire [2:0]           tol = tol4 ? 3'h4 : 3'h1;
	wire [1:0]           votes = {1'b0, lock_hist[0]} + {1'b0, lock_hist[1]}
		+ {1'b0, lock_hist[2]};
	always @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fb_cnt <= {`FB_WIDTH{1'b0}};
			ref_cnt <= {`REF_WIDTH{1'b0}};
			fb_pulse <= 1'b0;
			ref_pulse <= 1'b0;
			pump_up <= 1'b0;
			pump_dn <= 1'b0;
			pump_oe_n <= 1'b1;
			pump_gain <= 1'b0;
			lock_hist <= 3'h0;
			err_cnt <= 3'h0;
			locked <= 1'b0;
		end
		else if (!enable)
		begin
			fb_cnt <= {`FB_WIDTH{1'b0}}; // RULE16
			ref_cnt <= {`REF_WIDTH{1'b0}};
			fb_pulse <= 1'b0;
			ref_pulse <= 1'b0;
			pump_up <= 1'b0;
			pump_dn <= 1'b0;
			pump_oe_n <= 1'b1;
			lock_hist <= 3'h0;
			err_cnt <= 3'h0;
			locked <= 1'b0; // RULE16
			pump_gain <= gain_high;
		end
		else
		begin
			pump_gain <= gain_high; // RULE8
			fb_pulse <= 1'b0;
			ref_pulse <= 1'b0;
			if (vco_tick)
			begin
				if (fb_cnt <= 20'h00001)
				begin
					fb_cnt <= fb_value; // RULE15
					fb_pulse <= 1'b1; // RULE5
				end
				else
					fb_cnt <= fb_cnt - 20'h00001; // RULE2
			end
			if (ref_tick)
			begin
				if (ref_cnt <= 13'h0001)
				begin
					ref_cnt <= ref_value; // RULE15
					ref_pulse <= 1'b1; // RULE5
				end
				else
					ref_cnt <= ref_cnt - 13'h0001; // RULE2
			end
			// Phase-frequency detector: each edge sets its flag, both together reset
			if ((pump_up | ref_pulse) & (pump_dn | fb_pulse))
			begin
				pump_up <= 1'b0; // RULE9
				pump_dn <= 1'b0;
				// Phase error measured in undivided reference ticks
				lock_hist <= {lock_hist[1:0], (err_cnt <= tol)}; // RULE10 RULE11
				err_cnt <= 3'h0;
			end
			else
			begin
				pump_up <= pump_up | ref_pulse;
				pump_dn <= pump_dn | fb_pulse;
				if ((pump_up | pump_dn) && ref_tick && err_cnt != 3'h7)
					err_cnt <= err_cnt + 3'h1; // RULE10
			end
			// Drive only while correcting; otherwise high impedance
			pump_oe_n <= ~((pump_up | ref_pulse) ^ (pump_dn | fb_pulse)); // RULE9
			locked <= votes[1]; // RULE11
		end
	end
endmodule

//--- synth_divider_lock.v
`timescale 1ns/100ps
`include "synth_regs.vh"
// Operation
// RULE1: One shared reference, crystal or ref pin
// RULE2: Feedback counter 20 bits, reference 13 bits
// RULE3: Two host-writable divide sets per channel
// RULE4: Control bit picks active set per channel
// RULE5: Dividers bring both inputs to comparison rate
// RULE6: Four data writes make one divider setup
// RULE7: Host rewrites only inactive or idle sets
// RULE8: Gain bit 3 and 11 select pump level
// RULE9: Phase-frequency comparator drives tristate pump
// RULE10: Lock tolerance one or four reference cycles
// RULE11: Majority of last three lock measurements
// RULE12: Lock bits readable, masked onto interrupt
// RULE13: Locked to unlocked transition raises interrupt
// RULE14: One command swaps active divide set
// RULE15: Dividers reload at terminal count, pulse
// RULE16: Disabled channel idle, reports not locked
module synth_divider_lock
(
	input  wire        sys_clk,
	input  wire        arst_n,
	input  wire        xtal_ref_tick,
	input  wire        synth_ref_clock_input,
	input  wire [1:0]  vco_tick,
	input  wire        wr_en,
	input  wire        rd_en,
	input  wire [7:0]  addr,
	input  wire [15:0] wdata,
	input  wire [1:0]  lock_irq_mask,
	output reg  [7:0]  rdata,
	output reg         irq_n,
	output reg  [1:0]  pump_up,
	output reg  [1:0]  pump_dn,
	output reg  [1:0]  pump_oe_n,
	output reg  [1:0]  pump_gain_high
);
	reg  [15:0]          control;
	reg  [15:0]          data_stage [0:2];
	reg  [`FB_WIDTH-1:0] fb_set  [0:3];
	reg  [`REF_WIDTH-1:0] ref_set [0:3];
	reg  [1:0]           unlock_ev;
	reg  [1:0]           lock_prev;
	reg                  ref_tick;
	wire [1:0]           ch_up;
	wire [1:0]           ch_dn;
	wire [1:0]           ch_oe_n;
	wire [1:0]           ch_gain;
	wire [1:0]           ch_lock;
	wire [1:0]           ch_en;
	wire [1:0]           ch_sel;
	wire [1:0]           ch_tol;
	wire [1:0]           ch_gsel;
	wire                 ctrl_wr = wr_en && addr == `ADDR_CHANNEL_CONTROL;
	wire                 data_wr = wr_en && addr == `ADDR_CHANNEL_DATA;
	wire                 stat_rd = rd_en && addr == `ADDR_CHANNEL_STATUS;
	// Data word: [15:14] part, [13] channel, [12] set, [11:0] payload
	wire [1:0]           d_part = wdata[15:14];
	wire [1:0]           d_idx  = {wdata[13], wdata[12]};
	wire [1:0]           next_unlock_ev;
	integer              i;

	assign ch_en   = {control[`CTRL_ENABLE_1], control[`CTRL_ENABLE_0]};
	assign ch_sel  = {control[`CTRL_SET_SEL_1], control[`CTRL_SET_SEL_0]};
	assign ch_tol  = {control[`CTRL_TOL4_1], control[`CTRL_TOL4_0]};
	assign ch_gsel = {control[`CTRL_GAIN_1], control[`CTRL_GAIN_0]};
	// Set wins over a read-clear in the same cycle
	assign next_unlock_ev = (stat_rd ? 2'h0 : unlock_ev) | (lock_prev & ~ch_lock); // RULE13

	always @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			control <= `CTRL_RESET;
			for (i = 0; i < 3; i = i + 1)
				data_stage[i] <= 16'h0000;
			for (i = 0; i < 4; i = i + 1)
			begin
				fb_set[i] <= {`FB_WIDTH{1'b0}};
				ref_set[i] <= {`REF_WIDTH{1'b0}};
			end
			unlock_ev <= 2'h0;
			lock_prev <= 2'h0;
			ref_tick <= 1'b0;
			rdata <= 8'h00;
			irq_n <= 1'b1;
			pump_up <= 2'h0;
			pump_dn <= 2'h0;
			pump_oe_n <= 2'h3;
			pump_gain_high <= 2'h0;
		end
		else
		begin
			ref_tick <= control[`CTRL_REF_SRC] ? synth_ref_clock_input : xtal_ref_tick; // RULE1
			if (ctrl_wr)
			begin
				control <= wdata;
				// Swap bits toggle the active set without a read-modify-write
				control[`CTRL_SET_SEL_0] <= wdata[`CTRL_SWAP_0] ?
					~control[`CTRL_SET_SEL_0] : wdata[`CTRL_SET_SEL_0]; // RULE4 RULE14
				control[`CTRL_SET_SEL_1] <= wdata[`CTRL_SWAP_1] ?
					~control[`CTRL_SET_SEL_1] : wdata[`CTRL_SET_SEL_1]; // RULE14
				control[`CTRL_SWAP_0] <= 1'b0;
				control[`CTRL_SWAP_1] <= 1'b0;
			end
			// No interlock: host must only update an idle or inactive set
			if (data_wr)
			begin
				if (d_part == `DATA_SEL_COMMIT)
				begin
					fb_set[d_idx] <= {data_stage[1][7:0], data_stage[0][11:0]}; // RULE6 RULE3
					ref_set[d_idx] <= {data_stage[2][0], wdata[11:0]}; // RULE6
				end
				else
					data_stage[d_part] <= wdata; // RULE6
			end
			lock_prev <= ch_lock;
			unlock_ev <= next_unlock_ev;
			if (stat_rd)
				rdata <= {4'h0, unlock_ev, ch_lock}; // RULE12
			irq_n <= ~|((ch_lock | next_unlock_ev) & lock_irq_mask); // RULE12 RULE13
			pump_up <= ch_up;
			pump_dn <= ch_dn;
			pump_oe_n <= ch_oe_n;
			pump_gain_high <= ch_gain;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : chan
			synth_channel u_ch
			(
				.sys_clk   (sys_clk),
				.arst_n    (arst_n),
				.enable    (ch_en[g]),
				.ref_tick  (ref_tick),
				.vco_tick  (vco_tick[g]),
				.tol4      (ch_tol[g]),
				.gain_high (ch_gsel[g]),
				.fb_value  (fb_set[2 * g + ch_sel[g]]), // RULE4
				.ref_value (ref_set[2 * g + ch_sel[g]]),
				.pump_up   (ch_up[g]),
				.pump_dn   (ch_dn[g]),
				.pump_oe_n (ch_oe_n[g]),
				.pump_gain (ch_gain[g]),
				.locked    (ch_lock[g])
			);
		end
	endgenerate
endmodule

//--- synth_loop_model.sv
`timescale 1ns/100ps
module synth_loop_model
(
	input  wire        sys_clk,
	input  wire        arst_n,
	input  wire  [1:0] vco_slow,
	output logic       xtal_ref_tick,
	output logic       synth_ref_clock_input,
	output logic [1:0] vco_tick
);
	logic half;
	always @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
			half <= 1'b0;
		else
			half <= ~half;
	// Crystal ticks every cycle, ref pin at half rate
	assign xtal_ref_tick = arst_n;
	assign synth_ref_clock_input = half;
	// Half rate VCO pairs with the half rate ref pin
	assign vco_tick = ~vco_slow | {2{half}};
endmodule

//--- synth_divider_lock_monitor.sv
`timescale 1ns/100ps
module synth_divider_lock_monitor
(
	input wire        sys_clk,
	input wire        arst_n,
	input wire        wr_en,
	input wire        rd_en,
	input wire [7:0]  addr,
	input wire [15:0] wdata,
	input wire [1:0]  lock_irq_mask,
	input wire [7:0]  rdata,
	input wire        irq_n,
	input wire [1:0]  pump_up,
	input wire [1:0]  pump_dn,
	input wire [1:0]  pump_oe_n,
	input wire [1:0]  pump_gain_high
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// Lock bit may lag a disable, so wait for the count to saturate
	logic [2:0] off_cnt;
	logic       en1;
	always @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
		begin
			en1 <= 1'b0;
			off_cnt <= 3'h0;
		end
		else
		begin
			if (wr_en && addr == 8'hB3)
				en1 <= wdata[8];
			if ((wr_en && addr == 8'hB3) || en1)
				off_cnt <= 3'h0;
			else if (off_cnt != 3'h7)
				off_cnt <= off_cnt + 3'h1;
		end
	property p_mask_off; lock_irq_mask == 2'h0 |=> irq_n; endproperty
	a_mask_off: assert property (p_mask_off) else $error("irq while masked");
	property p_irq_cause; $fell(irq_n) |-> $past(lock_irq_mask) != 2'h0; endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without mask");
	property p_pump_drive; ((pump_up | pump_dn) & pump_oe_n) == 2'h0; endproperty
	a_pump_drive: assert property (p_pump_drive) else $error("pump not driven");
	property p_rdata_hold; !($past(rd_en) && $past(addr) == 8'hB4) |-> $stable(rdata); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
	property p_gain;
		wr_en && addr == 8'hB3 ##1 !wr_en [*4]
			|-> pump_gain_high == {$past(wdata[11], 4), $past(wdata[3], 4)};
	endproperty
	a_gain: assert property (p_gain) else $error("gain bit not applied");
	property p_off_idle0;
		wr_en && addr == 8'hB3 && !wdata[0] ##1 !wr_en [*4]
			|-> pump_oe_n[0] && !pump_up[0] && !pump_dn[0];
	endproperty
	a_off_idle0: assert property (p_off_idle0) else $error("pump 0 active");
	property p_off_idle1;
		wr_en && addr == 8'hB3 && !wdata[8] ##1 !wr_en [*4]
			|-> pump_oe_n[1] && !pump_up[1] && !pump_dn[1];
	endproperty
	a_off_idle1: assert property (p_off_idle1) else $error("pump 1 active");
	property p_off_status; off_cnt == 3'h7 && rd_en && addr == 8'hB4 |=> !rdata[1]; endproperty
	a_off_status: assert property (p_off_status) else $error("lock 1 while off");
	c_lock: cover property (rd_en && addr == 8'hB4 ##1 rdata[0]);
	c_event: cover property (rd_en && addr == 8'hB4 ##1 rdata[2]);
	c_irq: cover property (!irq_n);
endmodule
bind synth_divider_lock synth_divider_lock_monitor i_synth_divider_lock_monitor
(.sys_clk, .arst_n, .wr_en, .rd_en, .addr, .wdata, .lock_irq_mask, .rdata, .irq_n,
.pump_up, .pump_dn, .pump_oe_n, .pump_gain_high);

//--- rf_synth_divider_lock_tb.sv
`timescale 1ns/100ps
module rf_synth_divider_lock_tb;
	logic        sys_clk = 0, arst_n = 0, wr_en = 0, rd_en = 0, g;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000, c;
	logic [1:0]  lock_irq_mask = 2'h1, vco_slow = 2'h0;
	logic [19:0] k;
	wire         xt, rp, irq_n;
	wire  [1:0]  vt, up, dn, oe_n, gh;
	wire  [7:0]  rdata;
	int          fail_count = 0, tests_run = 0;
	always #5 sys_clk = ~sys_clk;
	synth_loop_model i_synth_loop_model(.sys_clk, .arst_n, .vco_slow,
		.xtal_ref_tick(xt), .synth_ref_clock_input(rp), .vco_tick(vt));
	synth_divider_lock i_synth_divider_lock(.sys_clk, .arst_n, .xtal_ref_tick(xt),
		.synth_ref_clock_input(rp), .vco_tick(vt), .wr_en, .rd_en, .addr, .wdata,
		.lock_irq_mask, .rdata, .irq_n, .pump_up(up), .pump_dn(dn), .pump_oe_n(oe_n),
		.pump_gain_high(gh));
	task summarize;
		$display("fail_count %0d tests_run %0d", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(string n, logic [19:0] s, logic [19:0] e);
		tests_run++;
		if (s !== e)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task gap(int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task wr(logic [7:0] a, logic [15:0] d);
		@(negedge sys_clk);
		wr_en = 1;
		addr = a;
		wdata = d;
		gap(1);
		wr_en = 0;
	endtask
	task rd;
		@(negedge sys_clk);
		rd_en = 1;
		addr = 8'hB4;
		gap(1);
		rd_en = 0;
	endtask
	// Four words per setup, last one commits
	task ds(logic s, logic [19:0] n, logic [12:0] r);
		wr(8'hB2, {3'h0, s, n[11:0]});
		wr(8'hB2, {3'h2, s, 4'h0, n[19:12]});
		wr(8'hB2, {3'h4, s, 11'h000, r[12]});
		wr(8'hB2, {3'h6, s, r[11:0]});
	endtask
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		summarize;
	end
	initial
	begin
		g = 1'($urandom(32'h5416) % 2);
		// Ratios below 6 could keep a 2:1 mismatch inside the wide tolerance
		k = 20'(8 + $urandom % 8);
		gap(2);
		arst_n = 1;
		chk("reset", 20'({rdata, irq_n, oe_n, gh, up, dn}), 20'h001C0);
		ds(0, k, k[12:0]);
		c = {12'h0, g, 3'h5};
		wr(8'hB3, c);
		ds(1, k * 2, k[12:0]);
		gap(6);
		chk("gain", 20'(gh), 20'(g));
		gap(400);
		rd;
		chk("lock", 20'(rdata[3:0]), 20'h1);
		chk("irq", 20'(irq_n), 20'h0);
		wr(8'hB3, c | 16'h0010);
		gap(400);
		// A status read clears the event and so the interrupt: look first
		chk("unlock irq", 20'(irq_n), 20'h0);
		rd;
		chk("unlock", 20'(rdata[2:0]), 20'h4);
		rd;
		chk("clear", 20'(rdata[2:0]), 20'h0);
		vco_slow = 2'h1;
		wr(8'hB3, c | 16'h8010);
		gap(400);
		rd;
		chk("ref pin lock", 20'(rdata[0]), 20'h1);
		wr(8'hB3, 16'h0000);
		gap(10);
		rd;
		chk("off", 20'({rdata[1:0], oe_n, up, dn}), 20'h30);
		summarize;
	end
endmodule
